// ===== fifo_flag_consts.vh
// constants for the fifo status-flag and reset-configuration block
`ifndef FIFO_FLAG_CONSTS_VH
`define FIFO_FLAG_CONSTS_VH

// =====================================================================
// register byte addresses
`define FFS_ADDR_CONFIG 12'h000
`define FFS_ADDR_EMPTY_OFS 12'h004
`define FFS_ADDR_FULL_OFS 12'h008
`define FFS_ADDR_STATUS 12'h00c

// =====================================================================
// offset register defaults per depth
`define FFS_DEPTH_256 13'h0100
`define FFS_DEPTH_512 13'h0200
`define FFS_OFS_DEF_D256 12'h01f
`define FFS_OFS_DEF_D512 12'h03f
`define FFS_OFS_DEF_LARGE 12'h07f

// =====================================================================
// config register fields
`define FFS_CFG_FALL_THROUGH_MODE 0
`define FFS_CFG_SYNC 1
`define FFS_CFG_EDEPTH_LO 2
`define FFS_CFG_EDEPTH_HI 3
`define FFS_CFG_FDEPTH_LO 4
`define FFS_CFG_FDEPTH_HI 5

// =====================================================================
// status register fields
`define FFS_ST_CNT_LO 0
`define FFS_ST_CNT_HI 12
`define FFS_ST_EMPTY 16
`define FFS_ST_FULL 17
`define FFS_ST_HALF 18
`define FFS_ST_AEMPTY 19
`define FFS_ST_AFULL 20

// =====================================================================
// flag buffering depths
`define FFS_BUF_SINGLE 2'h1
`define FFS_BUF_DOUBLE 2'h2
`define FFS_BUF_TRIPLE 2'h3

`endif

// ===== flag_buffer.v
// selectable one to three stage register buffer for a boundary flag
`timescale 1ns/1ps
`include "fifo_flag_consts.vh"
module flag_buffer (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // control
  input wire advance,
  input wire [1:0] depth,
  input wire resetValue,
  // flag
  input wire flagIn,
  output reg flagOut
);

  // =====================================================================
  // inner stages, clocked only on the owning side's edge
  wire [2:0] stage;

  assign stage[0] = flagIn;

  genvar k;
  generate
    for (k = 1; k < 3; k = k + 1) begin : g_stage
      reg stageQ;
      always @(posedge core_clk) begin
        if (!rst_n) begin
          stageQ <= resetValue;
        end else if (advance) begin
          stageQ <= stage[k-1];
        end
      end
      assign stage[k] = stageQ;
    end
  endgenerate

  // =====================================================================
  // output stage picks its source from the chosen depth
  always @(posedge core_clk) begin
    if (!rst_n) begin
      flagOut <= resetValue;
    end else if (advance) begin
      case (depth)
        `FFS_BUF_DOUBLE: flagOut <= stage[1];
        `FFS_BUF_TRIPLE: flagOut <= stage[2];
        default: flagOut <= stage[0];
      endcase
    end
  end

endmodule

// ===== fifo_flag_status.v
// fifo fill tracking, status flags, reset-time configuration and apb registers
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "fifo_flag_consts.vh"

// Notes on behaviour
// - async partial mode: almost-empty falls on read edge, rises on write edge
// - async partial mode: almost-full falls on write edge, rises on read edge
// - sync partial mode: almost-empty updates on read edges only
// - sync partial mode: almost-full updates on write edges only
// - buffering depth applies to empty and full flags only
// - each extra buffer stage delays the boundary flag one more edge
// - reset configuration selects single, double or triple boundary buffering
// - write-expand 0 (standard timing): first-load picks partial timing, read-expand picks buffering
// - straps 0,1,0 give standard, double buffered, asynchronous partial flags
// - read-expand 0, write-expand 1: fall-through, triple ready, double input-ready
// - both expand straps 1: standard, single buffered, asynchronous partials
// - empty offset defaults 31, 63 or 127 by depth
// - full offset defaults 31, 63 or 127 by depth
// - standard: almost-empty low up to n words, empty low only at zero
// - standard: half-full low from D/2+1, almost-full low from D-m
// - fall-through: almost-empty low up to n+1, output-ready high at zero
// - fall-through: half-full low from D/2+2, almost-full low from D+1-m
// - standard: full low exactly at D words
// - fall-through: input-ready high only at D+1 words
// - partial flag timing choice comes from the reset configuration
// - reset forces half-full, almost-full, full high, almost-empty low
// - offsets n and m live in 12-bit registers reset to defaults
module fifo_flag_status #(
  parameter [12:0] DEPTH = 13'h0100
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // reset-time configuration straps
  input wire firstLoadStrap,
  input wire readExpandIn,
  input wire writeExpandIn,
  // write side: edge strobe and write request
  input wire wrTick,
  input wire wrReq,
  // read side: edge strobe and read request
  input wire rdTick,
  input wire rdReq,
  // flags
  output wire emptyFlagN,
  output wire fullFlagN,
  output reg halfFullFlagN,
  output reg almostEmptyFlagN,
  output reg almostFullFlagN,
  output reg fallThroughMode,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);

  // =====================================================================
  // constants
  localparam [11:0] OFS_DEFAULT = (DEPTH == `FFS_DEPTH_256) ? `FFS_OFS_DEF_D256 :
                                  (DEPTH == `FFS_DEPTH_512) ? `FFS_OFS_DEF_D512 :
                                  `FFS_OFS_DEF_LARGE;
  localparam [12:0] HALF_MARK = (DEPTH >> 1) + 13'h0001;

  // =====================================================================
  // strap decode
  wire strapFwft;
  wire strapBothExpand;
  wire strapSync;
  wire [1:0] strapEmptyDepth;
  wire [1:0] strapFullDepth;

  assign strapFwft = !readExpandIn && writeExpandIn;
  assign strapBothExpand = readExpandIn && writeExpandIn;
  // both expand straps force async partials
  assign strapSync = firstLoadStrap && !strapBothExpand;
  assign strapEmptyDepth = strapFwft ? `FFS_BUF_TRIPLE :
                           (readExpandIn && !writeExpandIn) ? `FFS_BUF_DOUBLE :
                           `FFS_BUF_SINGLE;
  // double buffered full flag for 0,1,0
  assign strapFullDepth = strapFwft ? `FFS_BUF_DOUBLE :
                          (readExpandIn && !writeExpandIn) ? `FFS_BUF_DOUBLE :
                          `FFS_BUF_SINGLE;

  // =====================================================================
  // latched configuration
  reg cfgSync_q;
  reg [1:0] cfgEmptyDepth_q;
  reg [1:0] cfgFullDepth_q;

  // follow straps during reset, hold after release
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fallThroughMode <= strapFwft;
      cfgSync_q <= strapSync;
      cfgEmptyDepth_q <= strapEmptyDepth;
      cfgFullDepth_q <= strapFullDepth;
    end
  end

  // =====================================================================
  // offset registers
  reg [11:0] emptyOfs_q;
  reg [11:0] fullOfs_q;
  wire apbWrite;
  wire apbSetup;

  assign apbSetup = psel && penable && !pready;
  assign apbWrite = psel && penable && pready && pwrite;

  // offsets reset to defaults, software may rewrite them
  always @(posedge core_clk) begin
    if (!rst_n) begin
      emptyOfs_q <= OFS_DEFAULT;
      fullOfs_q <= OFS_DEFAULT;
    end else if (apbWrite) begin
      if (paddr == `FFS_ADDR_EMPTY_OFS) begin
        emptyOfs_q <= pwdata[11:0];
      end
      if (paddr == `FFS_ADDR_FULL_OFS) begin
        fullOfs_q <= pwdata[11:0];
      end
    end
  end

  // =====================================================================
  // fill count
  reg [12:0] fillCnt_q;
  reg [12:0] fillNext;
  wire [12:0] fwftAdd;
  wire [12:0] capacity;
  wire wrDo;
  wire rdDo;

  assign fwftAdd = {12'h000, fallThroughMode};
  // fall-through capacity counts the output register
  assign capacity = DEPTH + fwftAdd;
  assign wrDo = wrTick && wrReq && (fillCnt_q != capacity);
  assign rdDo = rdTick && rdReq && (fillCnt_q != 13'h0000);

  always @* begin
    fillNext = fillCnt_q;
    if (wrDo && !rdDo) begin
      fillNext = fillCnt_q + 13'h0001;
    end else if (rdDo && !wrDo) begin
      fillNext = fillCnt_q - 13'h0001;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      fillCnt_q <= 13'h0000;
    end else begin
      fillCnt_q <= fillNext;
    end
  end

  // =====================================================================
  // raw threshold compares on the updated count
  wire aeLow;
  wire afLow;
  wire hfLow;
  wire atZero;
  wire atCap;
  wire [13:0] fillPlusM;
  wire [13:0] capWide;

  // almost-empty low up to n words in standard timing
  // up to n+1 words in fall-through timing
  assign aeLow = fillNext <= ({1'b0, emptyOfs_q} + fwftAdd);
  // half-full low from D/2+1, from D/2+2
  assign hfLow = fillNext >= (HALF_MARK + fwftAdd);
  assign fillPlusM = {1'b0, fillNext} + {2'b00, fullOfs_q};
  assign capWide = {1'b0, capacity};
  // almost-full low from D-m or D+1-m
  assign afLow = fillPlusM >= capWide;
  assign atZero = fillNext == 13'h0000;
  assign atCap = fillNext == capacity;

  // =====================================================================
  // boundary flags
  wire emptyPin;
  wire fullPin;
  wire emptyReset;

  // empty low only at zero; output-ready high at zero
  assign emptyPin = fallThroughMode ? atZero : !atZero;
  // full low at D; input-ready high at D+1
  assign fullPin = fallThroughMode ? atCap : !atCap;
  // empty resets low in standard, high in fall-through
  assign emptyReset = strapFwft;

  // only the boundary flags are buffered
  // read-side edges move the empty flag through its stages
  flag_buffer u_emptyBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .advance(rdTick),
    .depth(cfgEmptyDepth_q),
    .resetValue(emptyReset),
    .flagIn(emptyPin),
    .flagOut(emptyFlagN)
  );

  // deeper setting adds write-side edges of delay
  flag_buffer u_fullBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .advance(wrTick),
    .depth(cfgFullDepth_q),
    .resetValue(1'b1),
    .flagIn(fullPin),
    .flagOut(fullFlagN)
  );

  // =====================================================================
  // partial flags
  always @(posedge core_clk) begin
    if (!rst_n) begin
      halfFullFlagN <= 1'b1;
      almostEmptyFlagN <= 1'b0;
      almostFullFlagN <= 1'b1;
    end else begin
      if (wrTick || rdTick) begin
        halfFullFlagN <= !hfLow;
      end
      if (cfgSync_q) begin
        if (rdTick) begin
          almostEmptyFlagN <= !aeLow;
        end
        if (wrTick) begin
          almostFullFlagN <= !afLow;
        end
      end else begin
        // falls on read edge, rises on write edge
        if (rdTick && aeLow) begin
          almostEmptyFlagN <= 1'b0;
        end else if (wrTick && !aeLow) begin
          almostEmptyFlagN <= 1'b1;
        end
        // falls on write edge, rises on read edge
        if (wrTick && afLow) begin
          almostFullFlagN <= 1'b0;
        end else if (rdTick && !afLow) begin
          almostFullFlagN <= 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // apb read mux
  reg [31:0] readData;
  reg addrHit;

  always @* begin
    readData = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      `FFS_ADDR_CONFIG: begin
        readData[`FFS_CFG_FALL_THROUGH_MODE] = fallThroughMode;
        readData[`FFS_CFG_SYNC] = cfgSync_q;
        readData[`FFS_CFG_EDEPTH_HI:`FFS_CFG_EDEPTH_LO] = cfgEmptyDepth_q;
        readData[`FFS_CFG_FDEPTH_HI:`FFS_CFG_FDEPTH_LO] = cfgFullDepth_q;
      end
      `FFS_ADDR_EMPTY_OFS: begin
        readData[11:0] = emptyOfs_q;
      end
      `FFS_ADDR_FULL_OFS: begin
        readData[11:0] = fullOfs_q;
      end
      `FFS_ADDR_STATUS: begin
        readData[`FFS_ST_CNT_HI:`FFS_ST_CNT_LO] = fillCnt_q;
        readData[`FFS_ST_EMPTY] = emptyFlagN;
        readData[`FFS_ST_FULL] = fullFlagN;
        readData[`FFS_ST_HALF] = halfFullFlagN;
        readData[`FFS_ST_AEMPTY] = almostEmptyFlagN;
        readData[`FFS_ST_AFULL] = almostFullFlagN;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // apb handshake: one wait state, answer registered
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apbSetup) begin
      pready <= 1'b1;
      pslverr <= !addrHit;
      prdata <= pwrite ? 32'h00000000 : readData;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ===== fifo_flag_status_properties.sv
// concurrent checks on the fifo flag status ports
`timescale 1ns/1ps
module fifo_flag_status_properties #(
  parameter [12:0] DEPTH = 13'h0100
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // straps and ticks
  input wire firstLoadStrap,
  input wire readExpandIn,
  input wire writeExpandIn,
  input wire wrTick,
  input wire rdTick,
  // flags
  input wire emptyFlagN,
  input wire fullFlagN,
  input wire almostEmptyFlagN,
  input wire almostFullFlagN,
  input wire fallThroughMode,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr
);
  reg syncQ;
  reg ftQ;
  // =====================================================================
  // strap copy taken while reset is low
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ftQ <= !readExpandIn && writeExpandIn;
      syncQ <= firstLoadStrap && !(readExpandIn && writeExpandIn);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // properties
  sequence s_access; psel && penable && !$past(penable); endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_wait; s_access |-> s_answer; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rst; $rose(rst_n) |-> fullFlagN && !almostEmptyFlagN && almostFullFlagN
    && emptyFlagN == ftQ; endproperty
  property p_mode; rst_n |-> fallThroughMode == ftQ; endproperty
  property p_aeFall; $fell(almostEmptyFlagN) |-> $past(rdTick); endproperty
  property p_aeRise; !syncQ && $rose(almostEmptyFlagN) |-> $past(wrTick); endproperty
  property p_aeSync; syncQ && $changed(almostEmptyFlagN) |-> $past(rdTick); endproperty
  property p_afFall; $fell(almostFullFlagN) |-> $past(wrTick); endproperty
  property p_afRise; !syncQ && $rose(almostFullFlagN) |-> $past(rdTick); endproperty
  property p_afSync; syncQ && $changed(almostFullFlagN) |-> $past(wrTick); endproperty
  property p_efTick; $changed(emptyFlagN) |-> $past(rdTick); endproperty
  property p_ffTick; $changed(fullFlagN) |-> $past(wrTick); endproperty
  a_wait: assert property (p_wait) else $error("pready not one wait state late");
  a_once: assert property (p_once) else $error("pready held over one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_rst: assert property (p_rst) else $error("flag reset levels wrong");
  a_mode: assert property (p_mode) else $error("mode differs from straps");
  a_aeFall: assert property (p_aeFall) else $error("almost-empty fell off read");
  a_aeRise: assert property (p_aeRise) else $error("almost-empty rose off write");
  a_aeSync: assert property (p_aeSync) else $error("almost-empty moved off read");
  a_afFall: assert property (p_afFall) else $error("almost-full fell off write");
  a_afRise: assert property (p_afRise) else $error("almost-full rose off read");
  a_afSync: assert property (p_afSync) else $error("almost-full moved off write");
  a_efTick: assert property (p_efTick) else $error("empty flag moved off read");
  a_ffTick: assert property (p_ffTick) else $error("full flag moved off write");
endmodule
bind fifo_flag_status fifo_flag_status_properties #(.DEPTH(DEPTH)) u_props (.core_clk,
  .rst_n, .firstLoadStrap, .readExpandIn, .writeExpandIn, .wrTick, .rdTick, .emptyFlagN,
  .fullFlagN, .almostEmptyFlagN, .almostFullFlagN, .fallThroughMode, .psel, .penable,
  .pready, .pslverr);

// ===== fifo_side_model.sv
// writer and reader model issuing a given number of requests on their ticks
`timescale 1ns/1ps
module fifo_side_model (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // commands
  input wire [12:0] wrNum,
  input wire [12:0] rdNum,
  input wire go,
  // ticks and requests
  output reg wrTick,
  output reg wrReq,
  output reg rdTick,
  output reg rdReq,
  output wire idle
);
  reg [1:0] ph = 2'h0;
  reg [12:0] wrLeft = 13'h0;
  reg [12:0] rdLeft = 13'h0;
  assign idle = (wrLeft == 13'h0) && (rdLeft == 13'h0);
  // write edges every 2 cycles, read edges every 4; requests toggle off tick
  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    wrTick <= ph[0];
    rdTick <= (ph == 2'h3);
    wrReq <= ph[0] ? (wrLeft != 13'h0) : ~wrReq;
    rdReq <= (ph == 2'h3) ? (rdLeft != 13'h0) : ~rdReq;
    if (!rst_n) begin
      wrLeft <= 13'h0;
      rdLeft <= 13'h0;
    end else if (go) begin
      wrLeft <= wrNum;
      rdLeft <= rdNum;
    end else begin
      if (ph[0] && wrLeft != 13'h0) wrLeft <= wrLeft - 13'h1;
      if (ph == 2'h3 && rdLeft != 13'h0) rdLeft <= rdLeft - 13'h1;
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench for the fifo flag status block
`timescale 1ns/1ps
module testbench;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg firstLoadStrap = 1'b0, readExpandIn = 1'b0, writeExpandIn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [12:0] wrNum = 13'h0, rdNum = 13'h0;
  reg er;
  wire wrTick, wrReq, rdTick, rdReq, idle, pready, pslverr;
  wire emptyFlagN, fullFlagN, halfFullFlagN, almostEmptyFlagN, almostFullFlagN;
  wire fallThroughMode;
  wire [31:0] prdata;
  integer err_count = 0, comparisons = 0, lvl = 0, n = 31, m = 31, fw = 0, i;
  localparam integer D = 256;
  // rows: straps, then expected config word
  localparam logic [8:0] ROWS [8] = '{{3'h0, 6'h14}, {3'h1, 6'h2d}, {3'h2, 6'h28},
    {3'h3, 6'h14}, {3'h4, 6'h16}, {3'h5, 6'h2f}, {3'h6, 6'h2a}, {3'h7, 6'h14}};
  localparam integer STD [14] = '{31, 32, 128, 129, 224, 225, 255, 256, 224, 129, 128,
    32, 31, 0};
  localparam integer FWL [9] = '{32, 33, 129, 130, 225, 226, 256, 257, 0};
  localparam integer OFL [5] = '{5, 6, 245, 246, 0};
  always #4 core_clk = ~core_clk;
  fifo_flag_status #(.DEPTH(13'h0100)) u_fifo_flag_status (.core_clk, .rst_n,
    .firstLoadStrap, .readExpandIn, .writeExpandIn, .wrTick, .wrReq, .rdTick, .rdReq,
    .emptyFlagN, .fullFlagN, .halfFullFlagN, .almostEmptyFlagN, .almostFullFlagN,
    .fallThroughMode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  fifo_side_model u_fifo_side_model (.core_clk, .rst_n, .wrNum, .rdNum, .go, .wrTick,
    .wrReq, .rdTick, .rdReq, .idle);
  // =====================================================================
  // tasks
  task results;
    begin
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      t = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && t < 20) begin
        t = t + 1;
        @(posedge core_clk);
      end
      if (t == 20) chk("pready", 0, 1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task flags;
    begin
      chk("flags", {emptyFlagN, fullFlagN, halfFullFlagN, almostEmptyFlagN,
        almostFullFlagN}, fw ? {lvl == 0, lvl == D + 1, lvl < D / 2 + 2, lvl > n + 1,
        lvl < D + 1 - m} : {lvl != 0, lvl != D, lvl < D / 2 + 1, lvl > n, lvl < D - m});
      apb(1'b0, 12'h00c, 32'h0);
      chk("count", rd[12:0], lvl);
    end
  endtask
  task rst(input [2:0] c);
    begin
      rst_n <= 1'b0;
      {firstLoadStrap, readExpandIn, writeExpandIn} <= c;
      repeat (4) @(posedge core_clk);
      #1;
      fw = (c == 3'h1 || c == 3'h5);
      chk("reset flags", {emptyFlagN, fullFlagN, halfFullFlagN, almostEmptyFlagN,
        almostFullFlagN}, {fw[0], 4'hd});
      @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      {firstLoadStrap, readExpandIn, writeExpandIn} <= ~c;
      lvl = 0;
      n = 31;
      m = 31;
    end
  endtask
  task move(input integer wn, input integer rn);
    integer k;
    begin
      @(posedge core_clk);
      wrNum <= wn;
      rdNum <= rn;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      k = 0;
      @(posedge core_clk);
      while (idle !== 1'b1 && k < 4000) begin
        k = k + 1;
        @(posedge core_clk);
      end
      if (k == 4000) chk("idle", 0, 1);
      repeat (16) @(posedge core_clk);
      lvl = lvl + wn - rn;
      if (lvl > D + fw) lvl = D + fw;
      if (lvl < 0) lvl = 0;
      #1 flags;
    end
  endtask
  task goTo(input integer t);
    begin
      if (t > lvl) move(t - lvl, 0);
      else move(0, lvl - t);
    end
  endtask
  // =====================================================================
  // main sequence
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      rst(ROWS[i][8:6]);
      apb(1'b0, 12'h000, 32'h0);
      chk("config", rd, ROWS[i][5:0]);
      chk("mode", fallThroughMode, ROWS[i][0]);
      apb(1'b0, 12'h004, 32'h0);
      chk("empty ofs", rd, 32'h1f);
      apb(1'b0, 12'h008, 32'h0);
      chk("full ofs", rd, 32'h1f);
    end
    rst(3'h0);
    foreach (STD[j]) goTo(STD[j]);
    goTo(256);
    move(4, 0);
    goTo(100);
    move(10, 5);
    goTo(0);
    move(0, 3);
    rst(3'h5);
    foreach (FWL[j]) goTo(FWL[j]);
    rst(3'h2);
    apb(1'b1, 12'h004, 32'h5);
    apb(1'b1, 12'h008, 32'ha);
    n = 5;
    m = 10;
    apb(1'b1, 12'h000, 32'hff);
    apb(1'b0, 12'h000, 32'h0);
    chk("config ro", rd, 32'h28);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", er, 1);
    chk("unmapped", rd, 0);
    foreach (OFL[j]) goTo(OFL[j]);
    results;
  end
  initial begin
    #600000;
    err_count = err_count + 1;
    results;
  end
endmodule
